// [src/icp_config_port.sv]
// indexed configuration port with key unlock and logical device banks
module icp_config_port #(
  parameter int NUM_LDEV  = 16,
  parameter bit ALT_ENABLE = 1'b0
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // host i/o requests
  input  wire icp_pkg::icp_io_req_type io_req,
  // read answer
  output icp_pkg::icp_io_rsp_type      io_rsp,
  // status
  output logic                         config_mode,
  output logic [7:0]                   ldev_sel
);

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int LW        = $clog2(NUM_LDEV);
  localparam int GLOB_SIZE = int'(icp_pkg::IDX_GLOBAL_TOP) + 1;
  localparam int GW        = $clog2(GLOB_SIZE);
  localparam int BANK_SIZE = 256;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    hit = (a == base);
  endfunction : hit

  function automatic logic key_is(input logic [7:0] d, input logic [7:0] key);
    key_is = (d == key);
  endfunction : key_is

  function automatic logic idx_is_select(input logic [7:0] idx);
    idx_is_select = (idx == icp_pkg::IDX_LDEV_SEL);
  endfunction : idx_is_select

  function automatic logic idx_is_global(input logic [7:0] idx);
    idx_is_global = (idx <= icp_pkg::IDX_GLOBAL_TOP);
  endfunction : idx_is_global

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [15:0] index_base;
  logic [15:0] data_base;
  logic        at_index;
  logic        at_data;
  logic        port_hit;

  assign index_base = ALT_ENABLE ? icp_pkg::ADDR_INDEX_ALT : icp_pkg::ADDR_INDEX_PRI;
  assign data_base  = 16'(index_base + icp_pkg::DATA_OFFSET);
  assign at_index   = hit(io_req.addr, index_base);
  assign at_data    = hit(io_req.addr, data_base);
  assign port_hit   = at_index || at_data;

  // ----------------------------------------------------------------
  // key strobes
  // ----------------------------------------------------------------
  logic index_wr;
  logic enter_wr;
  logic exit_wr;
  logic other_wr;

  assign index_wr = io_req.wr && at_index;
  assign enter_wr = index_wr && key_is(io_req.wdata, icp_pkg::KEY_ENTER);
  assign exit_wr  = index_wr && key_is(io_req.wdata, icp_pkg::KEY_EXIT);
  assign other_wr = index_wr && !enter_wr;

  // ----------------------------------------------------------------
  // key state machine
  // ----------------------------------------------------------------
  icp_pkg::icp_state_type state_reg;
  icp_pkg::icp_state_type state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      icp_pkg::ICP_LOCKED: begin
        if (enter_wr) begin
          state_next = icp_pkg::ICP_KEY_ONE;
        end
      end
      icp_pkg::ICP_KEY_ONE: begin
        if (enter_wr) begin
          state_next = icp_pkg::ICP_OPEN;
        end else if (other_wr) begin
          state_next = icp_pkg::ICP_LOCKED;
        end
      end
      icp_pkg::ICP_OPEN: begin
        if (exit_wr) begin
          state_next = icp_pkg::ICP_LOCKED;
        end
      end
      default: begin
        state_next = icp_pkg::ICP_LOCKED;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= icp_pkg::ICP_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // access qualifiers
  // ----------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] ldev_reg;
  logic       open;
  logic       open_next;
  logic       at_select;
  logic       at_global;
  logic       idx_wr;
  logic       index_rd;
  logic       data_wr;
  logic       data_rd;
  logic       sel_wr;
  logic       glob_wr;
  logic       dev_wr;

  assign open      = (state_reg == icp_pkg::ICP_OPEN);
  assign open_next = (state_next == icp_pkg::ICP_OPEN);
  assign at_select = idx_is_select(index_reg);
  assign at_global = idx_is_global(index_reg);
  assign idx_wr    = open && index_wr && !exit_wr;
  assign index_rd  = open && io_req.rd && at_index;
  assign data_wr   = open && io_req.wr && at_data;
  assign data_rd   = open && io_req.rd && at_data;
  assign sel_wr    = data_wr && at_select;
  assign glob_wr   = data_wr && !at_select && at_global;
  assign dev_wr    = data_wr && !at_select && !at_global;

  // ----------------------------------------------------------------
  // index and device select registers
  // ----------------------------------------------------------------
  logic [7:0]    index_next;
  logic [7:0]    ldev_next;
  logic [LW-1:0] dev_idx;

  assign index_next = idx_wr ? io_req.wdata : index_reg;
  assign ldev_next  = sel_wr ? io_req.wdata : ldev_reg;
  assign dev_idx    = ldev_reg[LW-1:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      index_reg <= icp_pkg::RESET_VALUE;
      ldev_reg  <= icp_pkg::RESET_VALUE;
    end else begin
      index_reg <= index_next;
      ldev_reg  <= ldev_next;
    end
  end

  // ----------------------------------------------------------------
  // global control registers
  // ----------------------------------------------------------------
  logic [7:0]    glob_mem [0:GLOB_SIZE-1];
  logic [GW-1:0] glob_idx;
  logic [7:0]    glob_rdata;

  assign glob_idx   = index_reg[GW-1:0];
  assign glob_rdata = glob_mem[glob_idx];

  always_ff @(posedge core_clk) begin
    if (glob_wr) begin
      glob_mem[glob_idx] <= io_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // logical device banks
  // ----------------------------------------------------------------
  logic [7:0] bank_rdata [0:NUM_LDEV-1];

  for (genvar g = 0; g < NUM_LDEV; g++) begin : g_bank
    logic [7:0] bank_mem [0:BANK_SIZE-1];
    logic       bank_wr;

    assign bank_wr       = dev_wr && (dev_idx == LW'(g));
    assign bank_rdata[g] = bank_mem[index_reg];

    always_ff @(posedge core_clk) begin
      if (bank_wr) begin
        bank_mem[index_reg] <= io_req.wdata;
      end
    end
  end : g_bank

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] cfg_rdata;
  logic [7:0] rdata_next;
  logic       rvalid_next;

  assign cfg_rdata   = at_select ? ldev_reg :
                       at_global ? glob_rdata : bank_rdata[dev_idx];
  assign rdata_next  = data_rd  ? cfg_rdata :
                       index_rd ? index_reg : icp_pkg::IDLE_DATA;
  assign rvalid_next = io_req.rd && port_hit;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      io_rsp <= '{rdata: icp_pkg::IDLE_DATA, rvalid: 1'b0};
    end else begin
      io_rsp <= '{rdata: rdata_next, rvalid: rvalid_next};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      config_mode <= 1'b0;
    end else begin
      config_mode <= open_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ldev_sel <= icp_pkg::RESET_VALUE;
    end else begin
      ldev_sel <= ldev_next;
    end
  end

endmodule : icp_config_port

// [src/icp_pkg.sv]
// constants and carrier types for the indexed configuration port
//
// Behaviour
// - the port decodes host i/o address 2e (4e with ALT_ENABLE) as the index port and 2f (4f with ALT_ENABLE) as the data port.
// - two back-to-back writes of 87 to the enable port (2e, or 4e) unlock config mode.
// - the index register shares its address with the function enable register.
// - the data register sits one address above the index register.
// - index 07 then a data write selects the logical device used by later accesses.
// - global control registers are reached without any logical device selection.
// - after selection, an index write then a data access reaches that device register.
// - a write of aa to the enable port leaves config mode and stops config accesses.
// - after exit the port runs normally and accepts a fresh entry key sequence.
package icp_pkg;

  // ----------------------------------------------------------------
  // port addresses and key values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_INDEX_PRI = 16'h002e;
  localparam logic [15:0] ADDR_INDEX_ALT = 16'h004e;
  localparam logic [15:0] DATA_OFFSET    = 16'h0001;
  localparam logic [7:0]  KEY_ENTER      = 8'h87;
  localparam logic [7:0]  KEY_EXIT       = 8'haa;
  localparam logic [7:0]  IDX_LDEV_SEL   = 8'h07;
  localparam logic [7:0]  IDX_GLOBAL_TOP = 8'h2f;
  localparam logic [7:0]  RESET_VALUE    = 8'h00;
  localparam logic [7:0]  IDLE_DATA      = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICP_LOCKED,
    ICP_KEY_ONE,
    ICP_OPEN
  } icp_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } icp_io_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } icp_io_rsp_type;

endpackage : icp_pkg

// [testbench/icp_config_port_properties.sv]
// assertion checker for the indexed configuration port
module icp_config_port_properties (
  input wire logic                    core_clk,
  input wire logic                    reset,
  input wire icp_pkg::icp_io_req_type io_req,
  input wire icp_pkg::icp_io_rsp_type io_rsp,
  input wire logic                    config_mode,
  input wire logic [7:0]              ldev_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire       ix  = io_req.addr == 16'h002e;
  wire       dx  = io_req.addr == 16'h002f;
  wire [7:0] d   = io_req.wdata;
  wire       k87 = io_req.wr && ix && d == 8'h87;
  wire       kaa = io_req.wr && ix && d == 8'haa;
  wire       dw  = config_mode && io_req.wr && dx;
  logic [7:0] idx_q;
  always_ff @(posedge core_clk)
    if (reset) idx_q <= 8'h00;
    else if (config_mode && io_req.wr && ix && !kaa) idx_q <= d;
  property p_rv; io_req.rd && (ix || dx) |=> io_rsp.rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; !io_req.rd |=> !io_rsp.rvalid; endproperty
  a_nrv: assert property (p_nrv) else $error("stray read answer");
  property p_lk; !config_mode && io_req.rd && dx |=> io_rsp.rdata == 8'hff; endproperty
  a_lk: assert property (p_lk) else $error("locked read not idle");
  property p_ent; $rose(config_mode) |-> $past(k87); endproperty
  a_ent: assert property (p_ent) else $error("unlock without key");
  property p_ex; config_mode && kaa |=> !config_mode; endproperty
  a_ex: assert property (p_ex) else $error("exit key ignored");
  property p_fall; $fell(config_mode) |-> $past(kaa); endproperty
  a_fall: assert property (p_fall) else $error("lock without exit key");
  property p_sel; $changed(ldev_sel) |-> $past(dw); endproperty
  a_sel: assert property (p_sel) else $error("device changed unasked");
  property p_idx; config_mode && io_req.rd && ix |=> io_rsp.rdata == idx_q; endproperty
  a_idx: assert property (p_idx) else $error("index readback wrong");
  c_ent: cover property ($rose(config_mode));
  c_sel: cover property ($changed(ldev_sel));
  c_rd: cover property (config_mode && io_req.rd && dx);
endmodule : icp_config_port_properties
bind icp_config_port icp_config_port_properties u_props (.core_clk(core_clk), .reset(reset),
  .io_req(io_req), .io_rsp(io_rsp), .config_mode(config_mode), .ldev_sel(ldev_sel));

// [testbench/icp_host.sv]
// host model issuing i/o port cycles
module icp_host (
  input  wire logic              core_clk,
  output icp_pkg::icp_io_req_type io_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial io_req = '0;
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_req = '{a, d, w, !w};
    @(negedge core_clk);
    io_req = '{~a, ~d, 1'b0, 1'b0};
  endtask : acc
endmodule : icp_host

// [testbench/test_indexed_config_port_unlock.sv]
// self-checking bench for the indexed configuration port
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_indexed_config_port_unlock;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  int fails = 0;
  int num_checks = 0;
  icp_pkg::icp_io_req_type io_req;
  icp_pkg::icp_io_rsp_type io_rsp;
  logic       config_mode;
  logic [7:0] ldev_sel;
  always #12.5 core_clk = ~core_clk;
  icp_host host (.core_clk(core_clk), .io_req(io_req));
  icp_config_port DUT (.core_clk(core_clk), .reset(reset), .io_req(io_req), .io_rsp(io_rsp),
    .config_mode(config_mode), .ldev_sel(ldev_sel));
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00);
    `CHK(io_rsp.rvalid, 1'b1)
    `CHK(io_rsp.rdata, e)
  endtask : rd
  task automatic put(input logic [7:0] i, input logic [7:0] v);
    wr(16'h002e, i);
    wr(16'h002f, v);
  endtask : put
  task automatic get(input logic [7:0] i, input logic [7:0] e);
    wr(16'h002e, i);
    rd(16'h002f, e);
  endtask : get
  task automatic t_locked;
    wr(16'h004e, 8'h87);
    wr(16'h004e, 8'h87);
    `CHK(config_mode, 1'b0)
    host.acc(1'b0, 16'h004e, 8'h00);
    `CHK(io_rsp.rvalid, 1'b0)
    put(8'h07, 8'h05);
    `CHK(ldev_sel, 8'h00)
    rd(16'h002f, 8'hff);
    wr(16'h002e, 8'h87);
    wr(16'h002e, 8'h30);
    `CHK(config_mode, 1'b0)
    wr(16'h002e, 8'h87);
    wr(16'h002e, 8'h87);
    `CHK(config_mode, 1'b1)
    $display("done locked and entry");
  endtask : t_locked
  task automatic t_regs;
    put(8'h07, 8'h05);
    `CHK(ldev_sel, 8'h05)
    rd(16'h002e, 8'h07);
    put(8'h30, 8'h01);
    put(8'h20, 8'h5a);
    put(8'h07, 8'h06);
    put(8'h30, 8'h02);
    get(8'h20, 8'h5a);
    put(8'h07, 8'h05);
    get(8'h30, 8'h01);
    $display("done registers");
  endtask : t_regs
  task automatic t_exit;
    wr(16'h002e, 8'haa);
    `CHK(config_mode, 1'b0)
    put(8'h07, 8'h09);
    `CHK(ldev_sel, 8'h05)
    rd(16'h002e, 8'hff);
    wr(16'h002e, 8'h87);
    wr(16'h002e, 8'h87);
    `CHK(config_mode, 1'b1)
    get(8'h07, 8'h05);
    wr(16'h002e, 8'haa);
    `CHK(config_mode, 1'b0)
    $display("done exit and re-entry");
  endtask : t_exit
  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    t_locked();
    t_regs();
    t_exit();
    report_and_stop();
  end
  initial begin
    #20us;
    fails++;
    report_and_stop();
  end
endmodule : test_indexed_config_port_unlock
